// ### shared/uir_defines.svh
// Register offsets, fields, reset values and timing for the IR/9-bit UART.
// Assumes the includer is a SystemVerilog design on a 32-bit AHB-Lite bus.
`ifndef UIR_DEFINES_SVH
`define UIR_DEFINES_SVH
`define UIR_ADDR_CTRL 8'h00
`define UIR_ADDR_TXD 8'h04
`define UIR_ADDR_RXD 8'h08
`define UIR_ADDR_STAT 8'h0c
`define UIR_ADDR_DIV 8'h10
`define UIR_CTRL_BAUD_LSB 0
`define UIR_CTRL_IR_BIT 4
`define UIR_CTRL_PIE_BIT 5
`define UIR_CTRL_FDIS_BIT 6
`define UIR_CTRL_RESET 7'h00
`define UIR_DIV_RESET 16'h0001
`define UIR_OVS 16
`define UIR_IR_PULSE_TICKS 3
`define UIR_IR_MIN_TICKS 1
`define UIR_STD_SAMPLE_A 7
`define UIR_STD_SAMPLE_B 8
`define UIR_STD_SAMPLE_C 9
`endif

// ### shared/uir_pkg.sv
// Types for the IR/9-bit UART.
// Assumes uir_defines.svh is compiled alongside.
package uir_pkg;
   typedef enum logic [1:0] {UIR_IDLE, UIR_START, UIR_BITS, UIR_STOP} uir_state_e;
   typedef struct packed {
      logic ninth;
      logic [7:0] data;
   } uir_char_s;
endpackage

// ### hdl/uir_uart.sv
// IR/9-bit UART core with an AHB-Lite register slave.
// Assumes a single AHB-Lite master and an asynchronous serial peer on RX/TX.
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "uir_defines.svh"
module uir_uart #(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [7:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Serial line
   input wire logic RX,
   output logic TX,
   // Interrupt
   output logic PARITY_IRQ
);
   import uir_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave
   logic [6:0] ctrl_ff;
   logic [DIV_W-1:0] div_ff;
   logic wr_pend_ff, rd_pend_ff;
   logic [7:0] addr_ff;
   logic [31:0] hrdata_ff;
   logic [1:0] tq_cnt_ff;
   uir_char_s tq_ff [2];
   logic tq_rd_ff;
   uir_char_s rx_reg_ff;
   logic rx_full_ff, rx_ovr_ff, rx_ferr_ff, irq_ff;
   logic tx_busy_ff;

   wire addr_phase = HSEL && HREADY && HTRANS[1];
   wire wr_ctrl = wr_pend_ff && addr_ff == `UIR_ADDR_CTRL;
   wire wr_div = wr_pend_ff && addr_ff == `UIR_ADDR_DIV;
   wire wr_txd = wr_pend_ff && addr_ff == `UIR_ADDR_TXD;
   wire rd_rxd = addr_phase && !HWRITE && HADDR == `UIR_ADDR_RXD;
   wire ir_mode = ctrl_ff[`UIR_CTRL_IR_BIT];
   wire par_en = ctrl_ff[`UIR_CTRL_PIE_BIT];
   wire tq_full = tq_cnt_ff == 2'd2;
   wire tq_empty = tq_cnt_ff == 2'd0;
   // Divider 0 would stall the baud tick, so it acts as 1
   wire [DIV_W-1:0] div_eff = (div_ff == '0) ? DIV_W'(1) : div_ff;
   wire [31:0] rd_mux =
      (HADDR == `UIR_ADDR_CTRL) ? {25'h0, ctrl_ff} :
      (HADDR == `UIR_ADDR_DIV) ? 32'(div_ff) :
      (HADDR == `UIR_ADDR_RXD) ? {22'h0, rx_full_ff, rx_reg_ff} :
      (HADDR == `UIR_ADDR_STAT) ? {26'h0, irq_ff, rx_ferr_ff, rx_ovr_ff, rx_full_ff, tx_busy_ff, tq_full} :
      32'h00000000;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff <= 8'h00;
         hrdata_ff <= 32'h00000000;
      end else begin
         wr_pend_ff <= addr_phase && HWRITE;
         rd_pend_ff <= addr_phase && !HWRITE;
         addr_ff <= HADDR;
         if (addr_phase && !HWRITE) begin
            hrdata_ff <= rd_mux;
         end
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_ff <= `UIR_CTRL_RESET;
         div_ff <= DIV_W'(`UIR_DIV_RESET);
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= HWDATA[6:0];
         end
         if (wr_div) begin
            div_ff <= HWDATA[DIV_W-1:0];
         end
      end
   end

   assign HRDATA = hrdata_ff;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Baud tick: clock / ratio, 16 ticks per bit
   logic [DIV_W-1:0] bcnt_ff;
   wire tick = bcnt_ff >= div_eff - DIV_W'(1);
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         bcnt_ff <= '0;
      end else begin
         bcnt_ff <= tick ? '0 : bcnt_ff + DIV_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Two-entry transmit buffer; a full buffer drops writes, shown in status
   wire tq_push = wr_txd && !tq_full;
   wire tq_pop;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         tq_cnt_ff <= 2'd0;
         tq_rd_ff <= 1'b0;
         tq_ff[0] <= '0;
         tq_ff[1] <= '0;
      end else begin
         if (tq_push) begin
            tq_ff[tq_rd_ff ^ tq_cnt_ff[0]] <= uir_char_s'(HWDATA[8:0]);
         end
         if (tq_pop) begin
            tq_rd_ff <= ~tq_rd_ff;
         end
         tq_cnt_ff <= tq_cnt_ff + {1'b0, tq_push} - {1'b0, tq_pop};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter: start, 8 data, ninth bit, one stop
   uir_state_e tst_ff;
   logic [3:0] tsub_ff, tbit_ff;
   logic [8:0] tsh_ff;
   logic tx_ff;
   assign tq_pop = tst_ff == UIR_IDLE && !tq_empty && tick;
   wire cur_bit = (tst_ff == UIR_START) ? 1'b0 : (tst_ff == UIR_BITS) ? tsh_ff[0] : 1'b1;
   // IR zero is a short low pulse at the start of the bit period
   wire ir_out = cur_bit || tsub_ff >= 4'(`UIR_IR_PULSE_TICKS);
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         tst_ff <= UIR_IDLE;
         tsub_ff <= 4'h0;
         tbit_ff <= 4'h0;
         tsh_ff <= 9'h000;
         tx_ff <= 1'b1;
         tx_busy_ff <= 1'b0;
      end else begin
         tx_ff <= (tst_ff == UIR_IDLE) ? 1'b1 : ir_mode ? ir_out : cur_bit;
         tx_busy_ff <= tst_ff != UIR_IDLE;
         if (tq_pop) begin
            tst_ff <= UIR_START;
            tsh_ff <= {tq_ff[tq_rd_ff].ninth, tq_ff[tq_rd_ff].data};
            tsub_ff <= 4'h0;
            tbit_ff <= 4'h0;
         end else if (tick && tst_ff != UIR_IDLE) begin
            tsub_ff <= tsub_ff + 4'h1;
            if (tsub_ff == 4'hf) begin
               case (tst_ff)
                  UIR_START: tst_ff <= UIR_BITS;
                  UIR_BITS: begin
                     tsh_ff <= {1'b1, tsh_ff[8:1]};
                     tbit_ff <= tbit_ff + 4'h1;
                     if (tbit_ff == 4'd8) begin
                        tst_ff <= UIR_STOP;
                     end
                  end
                  UIR_STOP: tst_ff <= UIR_IDLE;
                  default: tst_ff <= UIR_IDLE;
               endcase
            end
         end
      end
   end
   assign TX = tx_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Receiver
   uir_state_e rst_ff;
   logic [3:0] rsub_ff, rbit_ff, hcnt_ff;
   logic [8:0] rsh_ff;
   logic [2:0] vote_ff;
   logic rx_d_ff, ir_seen_ff;
   // Line as seen in standard polarity: IR high pulse means zero
   wire rx_line = ir_mode ? ~rx_d_ff : rx_d_ff;
   // IR: pulse counted in ticks; one accepted sample at mid-pulse
   wire ir_hit = ir_mode && rx_d_ff && hcnt_ff == 4'(`UIR_IR_MIN_TICKS);
   wire maj = (vote_ff[0] & vote_ff[1]) | (vote_ff[0] & vote_ff[2]) | (vote_ff[1] & vote_ff[2]);
   wire bit_val = ir_mode ? !(ir_seen_ff || ir_hit) : maj;
   wire bit_end = tick && rsub_ff == 4'hf;
   wire start_det = rst_ff == UIR_IDLE && (ir_mode ? ir_hit && tick : !rx_line);
   wire rx_done = bit_end && rst_ff == UIR_STOP;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rx_d_ff <= 1'b1;
         rst_ff <= UIR_IDLE;
         rsub_ff <= 4'h0;
         rbit_ff <= 4'h0;
         hcnt_ff <= 4'h0;
         rsh_ff <= 9'h000;
         vote_ff <= 3'h7;
         ir_seen_ff <= 1'b0;
      end else begin
         rx_d_ff <= RX;
         if (tick) begin
            hcnt_ff <= rx_d_ff ? ((hcnt_ff == 4'hf) ? hcnt_ff : hcnt_ff + 4'h1) : 4'h0;
         end
         if (start_det) begin
            rst_ff <= UIR_START;
            rsub_ff <= ir_mode ? 4'(`UIR_IR_MIN_TICKS + 1) : 4'h0;
            ir_seen_ff <= 1'b0;
            rbit_ff <= 4'h0;
         end else if (tick && rst_ff != UIR_IDLE) begin
            rsub_ff <= rsub_ff + 4'h1;
            if (ir_hit) begin
               ir_seen_ff <= 1'b1;
            end
            if (rsub_ff == 4'(`UIR_STD_SAMPLE_A)) begin
               vote_ff[0] <= rx_line;
            end
            if (rsub_ff == 4'(`UIR_STD_SAMPLE_B)) begin
               vote_ff[1] <= rx_line;
            end
            if (rsub_ff == 4'(`UIR_STD_SAMPLE_C)) begin
               vote_ff[2] <= rx_line;
            end
            if (bit_end) begin
               ir_seen_ff <= 1'b0;
               case (rst_ff)
                  UIR_START: rst_ff <= (!ir_mode && maj) ? UIR_IDLE : UIR_BITS;
                  UIR_BITS: begin
                     rsh_ff <= {bit_val, rsh_ff[8:1]};
                     rbit_ff <= rbit_ff + 4'h1;
                     if (rbit_ff == 4'd8) begin
                        rst_ff <= UIR_STOP;
                     end
                  end
                  UIR_STOP: rst_ff <= UIR_IDLE;
                  default: rst_ff <= UIR_IDLE;
               endcase
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive register and parity interrupt
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rx_reg_ff <= '0;
         rx_full_ff <= 1'b0;
         rx_ovr_ff <= 1'b0;
         rx_ferr_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         // New character wins over a read in the same cycle
         if (rx_done) begin
            rx_reg_ff <= uir_char_s'(rsh_ff);
            rx_full_ff <= 1'b1;
            rx_ovr_ff <= rx_full_ff && !rd_rxd;
            rx_ferr_ff <= !bit_val;
         end else if (rd_rxd) begin
            rx_full_ff <= 1'b0;
         end
         // Depends on PIE, a pending read and the held character, not on buffered data
         irq_ff <= par_en && rx_reg_ff.ninth && rx_full_ff && !rd_rxd;
      end
   end
   assign PARITY_IRQ = irq_ff;
endmodule // uir_uart

// ### verification/uir_peer.sv
// Remote serial node model: sends frames on RX and decodes frames seen on TX.
// Assumes the bench sets ir and div to match the block before any traffic.
`timescale 1ns/100ps
module uir_peer (
   // Clock and mode
   input wire logic clk,
   input wire logic ir,
   input wire logic [31:0] div,
   // Serial line
   input wire logic tx,
   output logic rx,
   output logic [8:0] got
);
   logic busy = 1'b0;
   logic rx_drv = 1'b1;
   event got_ev;
   ////////////////////////////////////////
   // Idle level follows the mode: dark line is low in infrared
   assign rx = busy ? rx_drv : !ir;
   task automatic hold(input logic v, input int n);
      rx_drv <= v;
      repeat (n) @(posedge clk);
   endtask
   task automatic send(input logic [8:0] c, input logic g);
      busy <= 1'b1;
      if (g) begin
         hold(1'b1, div);
         hold(1'b0, 20);
      end
      for (int i = 0; i < 11; i++) begin
         logic b;
         b = (i == 0) ? 1'b0 : (i == 10) ? 1'b1 : c[i-1];
         if (ir) begin
            hold(!b, 3 * div);
            hold(1'b0, 13 * div);
         end else begin
            hold(b, 16 * div);
         end
      end
      busy <= 1'b0;
   endtask
   // Infrared zero is a short low pulse, so infrared samples one tick into the bit and standard mode at mid-bit
   always begin
      @(negedge tx);
      repeat (ir ? div : 8 * div) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         repeat (16 * div) @(posedge clk);
         got[i] = tx;
      end
      repeat (16 * div) @(posedge clk);
      -> got_ev;
   end
endmodule // uir_peer

// ### verification/uir_uart_props.sv
// Checker for the IR/9-bit UART top ports.
// Assumes binding onto uir_uart; snoops control writes on the bus.
`timescale 1ns/100ps
`include "uir_defines.svh"
module uir_uart_props (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // Bus
   input wire logic HSEL,
   input wire logic [7:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   // Line and interrupt
   input wire logic TX,
   input wire logic PARITY_IRQ
);
   logic wr_ff, rd_ff, ir_ff, pie_ff, div1_ff;
   logic [7:0] wa_ff;
   wire take = HSEL & HREADY & HTRANS[1];
   wire rxd_rd = take & !HWRITE & (HADDR == `UIR_ADDR_RXD);
   wire ctrl_wr = wr_ff & (wa_ff == `UIR_ADDR_CTRL);
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         {wr_ff, rd_ff, ir_ff, pie_ff, div1_ff, wa_ff} <= {5'h01, 8'h00};
      end else begin
         {wr_ff, rd_ff, wa_ff} <= {take & HWRITE, take & !HWRITE, HADDR};
         if (ctrl_wr) {pie_ff, ir_ff} <= HWDATA[5:4];
         if (wr_ff && wa_ff == `UIR_ADDR_DIV) div1_ff <= (HWDATA[15:0] <= 16'h0001);
      end
   end
   ////////////////////////////////////////
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   chk_bus_okay: assert property (HREADYOUT && !HRESP) else $error("bus not ready or not okay");
   chk_unmapped_zero: assert property (take && !HWRITE && HADDR == 8'h14 |=> HRDATA == 32'h0)
      else $error("unmapped read not zero");
   chk_rdata_hold: assert property ($changed(HRDATA) |-> rd_ff) else $error("read data moved without read");
   chk_irq_read_clear: assert property (rxd_rd && PARITY_IRQ |=> !PARITY_IRQ)
      else $error("irq kept after receive read");
   chk_irq_enable: assert property ($rose(PARITY_IRQ) |-> pie_ff) else $error("irq while disabled");
   chk_irq_hold: assert property (PARITY_IRQ && pie_ff && !rxd_rd && !ctrl_wr |=> PARITY_IRQ)
      else $error("irq dropped early");
   chk_ir_pulse: assert property ($fell(TX) && ir_ff && div1_ff |-> !TX [*3] ##1 TX)
      else $error("infrared pulse width wrong");
   chk_std_width: assert property ($fell(TX) && !ir_ff |-> !TX [*8])
      else $error("standard bit too short");
   cover property (rxd_rd && PARITY_IRQ);
   cover property ($fell(TX) && ir_ff);
   cover property ($rose(PARITY_IRQ));
endmodule // uir_uart_props

// ### verification/uir_uart_tb.sv
// Self-checking bench for the IR/9-bit UART.
// Assumes uir_peer and uir_uart_props are compiled alongside.
`timescale 1ns/100ps
`include "uir_defines.svh"
module uir_uart_tb;
   logic clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ir_m = 1'b0, dp_chk = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [7:0] haddr = 8'h00;
   logic [31:0] hwdata = 32'h0, rdq[$];
   logic [8:0] c, got, txq[$];
   string nmq[$];
   int err_total = 0, samples_checked = 0, seed = 74288, div_m = 2;
   wire [31:0] hrdata;
   wire hreadyout, hresp, tx, rx, irq;
   always #5 clk = ~clk;
   uir_uart uut (.CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
      .HRESP(hresp), .RX(rx), .TX(tx), .PARITY_IRQ(irq));
   uir_peer u_peer (.clk(clk), .ir(ir_m), .div(div_m), .tx(tx), .rx(rx), .got(got));
   ////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done;
      if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wait_rdy;
      int n = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1) begin
         @(posedge clk);
         if (++n > 50) begin err_total++; test_done; end
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input string nm);
      @(posedge clk);
      {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, a, w};
      wait_rdy;
      {hsel, htrans, hwdata, dp_chk} <= {1'b0, 2'b00, w ? d : 32'h0, !w};
      if (!w) begin rdq.push_back(d); nmq.push_back(nm); end
      wait_rdy;
      dp_chk <= 1'b0;
   endtask
   task automatic drain;
      int n = 0;
      while (txq.size() > 0 && n++ < 2000) @(posedge clk);
      if (txq.size() > 0) begin err_total++; test_done; end
   endtask
   task automatic rx_frame(input logic [8:0] ch, input logic g);
      u_peer.send(ch, g);
      repeat (4) @(posedge clk);
   endtask
   always @(posedge clk) if (dp_chk && hreadyout) check(nmq.pop_front(), hrdata, rdq.pop_front());
   always @(u_peer.got_ev) check("tx_char", {23'h0, got}, {23'h0, txq.pop_front()});
   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      bus(0, `UIR_ADDR_CTRL, 32'h0, "ctrl");
      bus(0, `UIR_ADDR_DIV, 32'h1, "div");
      bus(0, 8'h14, 32'h0, "unmapped");
      bus(1, `UIR_ADDR_DIV, 32'h2, "");
      bus(1, `UIR_ADDR_CTRL, 32'h60, "");
      repeat (3) begin
         c = 9'($random(seed));
         txq.push_back(c);
         bus(1, `UIR_ADDR_TXD, {23'h0, c}, "");
      end
      // Buffer full while the first char still shifts out; next write is dropped
      bus(0, `UIR_ADDR_STAT, 32'h03, "stat_full");
      bus(1, `UIR_ADDR_TXD, 32'h155, "");
      drain;
      rx_frame(9'h1c5, 1'b0);
      check("irq_set", {31'h0, irq}, 32'h1);
      bus(0, `UIR_ADDR_STAT, 32'h24, "stat_addr");
      bus(0, `UIR_ADDR_RXD, 32'h3c5, "rxd_addr");
      check("irq_clear", {31'h0, irq}, 32'h0);
      rx_frame(9'h0a7, 1'b0);
      bus(0, `UIR_ADDR_STAT, 32'h04, "stat_data");
      bus(0, `UIR_ADDR_RXD, 32'h2a7, "rxd_data");
      bus(1, `UIR_ADDR_CTRL, 32'h0, "");
      rx_frame(9'h1ff, 1'b0);
      bus(0, `UIR_ADDR_STAT, 32'h04, "stat_masked");
      bus(0, `UIR_ADDR_RXD, 32'h3ff, "rxd_masked");
      bus(1, `UIR_ADDR_DIV, 32'h1, "");
      bus(1, `UIR_ADDR_CTRL, 32'h30, "");
      ir_m <= 1'b1;
      div_m <= 1;
      // Plain eight-bit traffic in infrared mode, ninth bit kept clear
      c = {1'b0, 8'($random(seed))};
      txq.push_back(c);
      bus(1, `UIR_ADDR_TXD, {23'h0, c}, "");
      drain;
      rx_frame(9'h05a, 1'b1);
      bus(0, `UIR_ADDR_RXD, 32'h25a, "rxd_ir");
      bus(0, `UIR_ADDR_STAT, 32'h0, "stat_ir");
      test_done;
   end
endmodule // uir_uart_tb
bind uir_uart uir_uart_props u_props (.CLK(CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
   .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .TX(TX), .PARITY_IRQ(PARITY_IRQ));
